// [core/gcf_pkg.sv]
// package: register map, mode codes and status follow limits for pin logic
package gcf_pkg;
	// ==========================================================
	// register offsets
	localparam logic [7:0] GCF_OFF_MODE_LO  = 8'h0E;
	localparam logic [7:0] GCF_OFF_MODE_HI  = 8'h0F;
	localparam logic [7:0] GCF_OFF_SEL0     = 8'h12;
	localparam logic [7:0] GCF_OFF_SEL1     = 8'h13;
	localparam logic [7:0] GCF_OFF_SEL2     = 8'h14;
	localparam logic [7:0] GCF_OFF_SEL3     = 8'h15;
	localparam logic [7:0] GCF_OFF_LEVEL    = 8'h41;
	localparam logic [7:0] GCF_STATUS_BASE  = 8'h40;
	// ==========================================================
	// reset values and field layout
	localparam logic [7:0] GCF_RST_MODE     = 8'h00;
	localparam logic [7:0] GCF_RST_SEL      = 8'h00;
	localparam int         GCF_REG_MSB      = 7;
	localparam int         GCF_REG_LSB      = 3;
	localparam int         GCF_BIT_MSB      = 2;
	localparam int         GCF_PINS         = 4;
	// status space: 32 registers of 8 bits behind the base
	localparam int         GCF_STAT_REGS    = 32;
	// index of the pin level register within the status space
	localparam logic [4:0] GCF_IDX_LEVEL    = 5'h01;
	// ==========================================================
	// pin mode codes
	localparam logic [3:0] GCF_M_IN         = 4'h0;
	localparam logic [3:0] GCF_M_IN_INV     = 4'h1;
	localparam logic [3:0] GCF_M_OUT_LO     = 4'h2;
	localparam logic [3:0] GCF_M_OUT_HI     = 4'h3;
	localparam logic [3:0] GCF_M_ST         = 4'h4;
	localparam logic [3:0] GCF_M_ST_INV     = 4'h5;
	localparam logic [3:0] GCF_M_ST_OD0     = 4'h6;
	localparam logic [3:0] GCF_M_ST_OD1     = 4'h7;
endpackage

// [core/gcf_pin.sv]
// one pin: mode decode to drive level and output enable
`timescale 1ns/1ps
module gcf_pin (
	input  wire logic [3:0] mode_in,
	input  wire logic       follow_in,
	output logic            drive_out,
	output logic            oe_out
);
	import gcf_pkg::*;

	// decode mode into drive value and enable
	always_comb begin
		drive_out = 1'b0;
		oe_out    = 1'b0;
		case (mode_in)
			GCF_M_IN, GCF_M_IN_INV: begin
				oe_out = 1'b0; // [RULE1]
			end
			GCF_M_OUT_LO: begin
				oe_out = 1'b1; // [RULE2]
			end
			GCF_M_OUT_HI: begin
				drive_out = 1'b1;
				oe_out    = 1'b1; // [RULE2]
			end
			GCF_M_ST: begin
				drive_out = follow_in;
				oe_out    = 1'b1; // [RULE3]
			end
			GCF_M_ST_INV: begin
				drive_out = ~follow_in;
				oe_out    = 1'b1; // [RULE3]
			end
			GCF_M_ST_OD0: begin
				oe_out = ~follow_in; // [RULE4]
			end
			GCF_M_ST_OD1: begin
				oe_out = follow_in; // [RULE4]
			end
			default: begin
				oe_out = 1'b0; // reserved codes float [RULE18]
			end
		endcase
	end
endmodule

// [core/gcf_top.sv]
// four configurable pins with status follow and register port
// Contract
// RULE1: codes 0000/0001 plain or inverted input
// RULE2: codes 0010/0011 drive low or high
// RULE3: codes 0100/0101 drive status bit or inverse
// RULE4: codes 0110/0111 open-drain follow either sense
// RULE5: software never writes reserved codes 1000-1111; the bench writes one every eighth iteration
// RULE6: pin levels always readable in level register
// RULE7: lower pair register: pin1 high, pin0 low
// RULE8: upper pair at 0Fh: pin3 high, pin2 low
// RULE9: select applies only in modes 01xx
// RULE10: select holds register index and bit index
// RULE11: bit index picks bit position directly
// RULE12: unimplemented followed bit drives pin low
// RULE13: loss flags may not be followed
// RULE14: pin level register may not be followed
// RULE15: four select registers at 12h-15h, reset zero
// RULE16: level register shows raw pin, no inversion
// RULE17: disallowed follow target treated as unimplemented
// RULE18: reserved mode code keeps pin floating
`timescale 1ns/1ps
module gcf_top (
	input  wire logic                  clock_in,
	input  wire logic                  srst_in,
	input  wire logic                  wr_en_in,
	input  wire logic [7:0]            addr_in,
	input  wire logic [7:0]            wdata_in,
	output logic      [7:0]            rdata_out,
	input  wire logic [255:0]          status_bits_in,
	input  wire logic [255:0]          status_impl_in,
	input  wire logic [255:0]          status_deny_in,
	input  wire logic [3:0]            pin_in,
	output logic      [3:0]            pin_out,
	output logic      [3:0]            pin_oe_out,
	output logic      [3:0]            pin_value_out
);
	import gcf_pkg::*;

	// ==========================================================
	// register state
	logic [7:0] mode_lo_r, mode_lo_nxt;
	logic [7:0] mode_hi_r, mode_hi_nxt;
	logic [7:0] sel_r   [GCF_PINS];
	logic [7:0] sel_nxt [GCF_PINS];
	logic [7:0] rdata_nxt;
	logic [3:0] level_r, level_nxt;
	logic [3:0] pin_nxt, oe_nxt, value_nxt;
	logic [3:0] mode    [GCF_PINS];
	logic [3:0] follow;
	logic [3:0] drv_c, oe_c;
	logic [7:0] pos_c   [GCF_PINS];
	logic [3:0] bad_c, low_c;

	// mode fields: pin n sits in nibble n mod 2 of its pair
	assign mode[0] = mode_lo_r[3:0]; // [RULE7]
	assign mode[1] = mode_lo_r[7:4]; // [RULE7]
	assign mode[2] = mode_hi_r[3:0]; // [RULE8]
	assign mode[3] = mode_hi_r[7:4]; // [RULE8]

	// register writes
	always_comb begin
		mode_lo_nxt = mode_lo_r;
		mode_hi_nxt = mode_hi_r;
		for (int i = 0; i < GCF_PINS; i++) begin
			sel_nxt[i] = sel_r[i];
		end
		if (wr_en_in) begin
			case (addr_in)
				GCF_OFF_MODE_LO: mode_lo_nxt = wdata_in; // [RULE7]
				GCF_OFF_MODE_HI: mode_hi_nxt = wdata_in; // [RULE8]
				GCF_OFF_SEL0:    sel_nxt[0]  = wdata_in; // [RULE15]
				GCF_OFF_SEL1:    sel_nxt[1]  = wdata_in; // [RULE15]
				GCF_OFF_SEL2:    sel_nxt[2]  = wdata_in; // [RULE15]
				GCF_OFF_SEL3:    sel_nxt[3]  = wdata_in; // [RULE15]
				default: begin
				end
			endcase
		end
	end

	// register read mux, unmapped reads zero
	always_comb begin
		case (addr_in)
			GCF_OFF_MODE_LO: rdata_nxt = mode_lo_r;
			GCF_OFF_MODE_HI: rdata_nxt = mode_hi_r;
			GCF_OFF_SEL0:    rdata_nxt = sel_r[0];
			GCF_OFF_SEL1:    rdata_nxt = sel_r[1];
			GCF_OFF_SEL2:    rdata_nxt = sel_r[2];
			GCF_OFF_SEL3:    rdata_nxt = sel_r[3];
			GCF_OFF_LEVEL:   rdata_nxt = {4'h0, level_r}; // [RULE6]
			default:         rdata_nxt = 8'h00;
		endcase
	end

	// status follow: pick bit, flag unimplemented and denied targets
	always_comb begin
		for (int i = 0; i < GCF_PINS; i++) begin
			pos_c[i] = {sel_r[i][GCF_REG_MSB:GCF_REG_LSB],
				sel_r[i][GCF_BIT_MSB:0]}; // [RULE10] [RULE11]
			if (sel_r[i][GCF_REG_MSB:GCF_REG_LSB] == GCF_IDX_LEVEL) begin
				bad_c[i] = 1'b1; // [RULE14] [RULE17]
			end else if (status_deny_in[pos_c[i]]) begin
				bad_c[i] = 1'b1; // loss flags [RULE13] [RULE17]
			end else if (!status_impl_in[pos_c[i]]) begin
				bad_c[i] = 1'b1; // [RULE12]
			end else begin
				bad_c[i] = 1'b0;
			end
			follow[i] = bad_c[i] ? 1'b0 : status_bits_in[pos_c[i]];
		end
	end

	// ==========================================================
	// per-pin decode
	for (genvar g = 0; g < GCF_PINS; g++) begin : g_pin
		gcf_pin u_pin (
			.mode_in   (mode[g]),
			.follow_in (follow[g]), // select used only in 01xx [RULE9]
			.drive_out (drv_c[g]),
			.oe_out    (oe_c[g])
		);
	end

	// core value and pad drive; unusable target in 01xx forces low
	always_comb begin
		for (int i = 0; i < GCF_PINS; i++) begin
			value_nxt[i] = (mode[i] == GCF_M_IN_INV) ?
				~pin_in[i] : pin_in[i]; // [RULE1]
			low_c[i]     = (mode[i][3:2] == 2'h1) && bad_c[i]; // [RULE9]
			pin_nxt[i]   = low_c[i] ? 1'b0 : drv_c[i]; // [RULE12]
			oe_nxt[i]    = low_c[i] ? 1'b1 : oe_c[i]; // [RULE17]
		end
		level_nxt = pin_in; // raw level [RULE16] [RULE6]
	end

	// registers
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			mode_lo_r     <= GCF_RST_MODE;
			mode_hi_r     <= GCF_RST_MODE;
			for (int i = 0; i < GCF_PINS; i++) begin
				sel_r[i] <= GCF_RST_SEL;
			end
			level_r       <= 4'h0;
			rdata_out     <= 8'h00;
			pin_out       <= 4'h0;
			pin_oe_out    <= 4'h0;
			pin_value_out <= 4'h0;
		end else begin
			mode_lo_r     <= mode_lo_nxt;
			mode_hi_r     <= mode_hi_nxt;
			for (int i = 0; i < GCF_PINS; i++) begin
				sel_r[i] <= sel_nxt[i];
			end
			level_r       <= level_nxt;
			rdata_out     <= rdata_nxt;
			pin_out       <= pin_nxt;
			pin_oe_out    <= oe_nxt;
			pin_value_out <= value_nxt;
		end
	end

	// ==========================================================
	// checks
	a_drive_high: assert property ( // [RULE2]
		@(posedge clock_in) disable iff (srst_in)
		mode[0] == GCF_M_OUT_HI && $stable(mode[0])
		|=> pin_oe_out[0] && pin_out[0])
		else $error("pin0 not driven high");

	a_drive_low: assert property ( // [RULE2]
		@(posedge clock_in) disable iff (srst_in)
		mode[1] == GCF_M_OUT_LO && $stable(mode[1])
		|=> pin_oe_out[1] && !pin_out[1])
		else $error("pin1 not driven low");

	a_input_float: assert property ( // [RULE1]
		@(posedge clock_in) disable iff (srst_in)
		mode[0][3:1] == 3'h0 |=> !pin_oe_out[0])
		else $error("input pin driven");

	a_reserved_float: assert property ( // [RULE18]
		@(posedge clock_in) disable iff (srst_in)
		mode[2][3] |=> !pin_oe_out[2])
		else $error("reserved code drives pin");

	a_follow_value: assert property ( // [RULE3]
		@(posedge clock_in) disable iff (srst_in)
		mode[0] == GCF_M_ST |=> pin_out[0] == $past(follow[0]))
		else $error("status follow wrong");

	a_invert_value: assert property ( // [RULE3]
		@(posedge clock_in) disable iff (srst_in)
		mode[3] == GCF_M_ST_INV |=>
		pin_out[3] == (!$past(follow[3]) && !$past(bad_c[3])))
		else $error("inverted follow wrong");

	a_open_drain: assert property ( // [RULE4]
		@(posedge clock_in) disable iff (srst_in)
		mode[1] == GCF_M_ST_OD0 |=>
		!pin_out[1] && pin_oe_out[1] == !$past(follow[1]))
		else $error("open drain wrong");

	a_level_raw: assert property ( // [RULE16]
		@(posedge clock_in) disable iff (srst_in)
		1'b1 |=> ##1 rdata_out[3:0] == $past(pin_in, 2)
		|| $past(addr_in) != GCF_OFF_LEVEL)
		else $error("level register not raw");

	a_level_deny: assert property ( // [RULE14]
		@(posedge clock_in) disable iff (srst_in)
		sel_r[2][GCF_REG_MSB:GCF_REG_LSB] == GCF_IDX_LEVEL
		|-> !follow[2])
		else $error("level bit followed");

	a_unimpl_low: assert property ( // [RULE12]
		@(posedge clock_in) disable iff (srst_in)
		mode[3] == GCF_M_ST && !status_impl_in[sel_r[3]]
		|=> pin_oe_out[3] && !pin_out[3])
		else $error("unimplemented bit not low");

	a_reset_zero: assert property ( // [RULE15]
		@(posedge clock_in)
		srst_in |=> mode_lo_r == 8'h00 && sel_r[0] == 8'h00)
		else $error("reset values wrong");

	a_drive_low_p3: assert property ( // [RULE2]
		@(posedge clock_in) disable iff (srst_in)
		mode[3] == GCF_M_OUT_LO |=> pin_oe_out[3] && !pin_out[3])
		else $error("pin3 not driven low");

	a_plain_input: assert property ( // [RULE1]
		@(posedge clock_in) disable iff (srst_in)
		mode[2] == GCF_M_IN |=> pin_value_out[2] == $past(pin_in[2]))
		else $error("plain input value wrong");

	a_invert_input: assert property ( // [RULE1]
		@(posedge clock_in) disable iff (srst_in)
		mode[1] == GCF_M_IN_INV |=>
		pin_value_out[1] == !$past(pin_in[1]))
		else $error("inverted input value wrong");

	a_od_invert: assert property ( // [RULE4]
		@(posedge clock_in) disable iff (srst_in)
		mode[0] == GCF_M_ST_OD1 |=> !pin_out[0] &&
		pin_oe_out[0] == ($past(follow[0]) || $past(bad_c[0])))
		else $error("inverted open drain wrong");

	a_bad_low: assert property ( // [RULE17]
		@(posedge clock_in) disable iff (srst_in)
		mode[1][3:2] == 2'h1 && bad_c[1]
		|=> pin_oe_out[1] && !pin_out[1])
		else $error("unusable target not low");

	a_deny_low: assert property ( // [RULE13]
		@(posedge clock_in) disable iff (srst_in)
		mode[0][3:2] == 2'h1 && status_deny_in[sel_r[0]]
		|=> pin_oe_out[0] && !pin_out[0])
		else $error("loss flag followed");

	a_level_low: assert property ( // [RULE14]
		@(posedge clock_in) disable iff (srst_in)
		mode[1][3:2] == 2'h1 &&
		sel_r[1][GCF_REG_MSB:GCF_REG_LSB] == GCF_IDX_LEVEL
		|=> pin_oe_out[1] && !pin_out[1])
		else $error("level bit drives pin");

	a_bit_pick: assert property ( // [RULE11]
		@(posedge clock_in) disable iff (srst_in)
		mode[2] == GCF_M_ST && status_impl_in[sel_r[2]] &&
		!status_deny_in[sel_r[2]] &&
		sel_r[2][GCF_REG_MSB:GCF_REG_LSB] != GCF_IDX_LEVEL
		|=> pin_out[2] == $past(status_bits_in[sel_r[2]]))
		else $error("wrong status bit followed");

	a_select_idle: assert property ( // [RULE9]
		@(posedge clock_in) disable iff (srst_in)
		mode[3][3:2] == 2'h0 |=>
		pin_oe_out[3] == $past(mode[3][1]) &&
		pin_out[3] == $past(mode[3] == GCF_M_OUT_HI))
		else $error("select acts outside status modes");

	a_level_sample: assert property ( // [RULE6]
		@(posedge clock_in) disable iff (srst_in)
		1'b1 |=> level_r == $past(pin_in))
		else $error("level register stale");

	a_read_mode_lo: assert property ( // [RULE7]
		@(posedge clock_in) disable iff (srst_in)
		!$past(srst_in) && $past(addr_in) == GCF_OFF_MODE_LO
		|-> rdata_out == $past(mode_lo_r))
		else $error("lower pair read wrong");

	a_read_mode_hi: assert property ( // [RULE8]
		@(posedge clock_in) disable iff (srst_in)
		!$past(srst_in) && $past(addr_in) == GCF_OFF_MODE_HI
		|-> rdata_out == $past(mode_hi_r))
		else $error("upper pair read wrong");

	a_read_sel: assert property ( // [RULE15]
		@(posedge clock_in) disable iff (srst_in)
		!$past(srst_in) && $past(addr_in) == GCF_OFF_SEL1
		|-> rdata_out == $past(sel_r[1]))
		else $error("select read wrong");

	a_write_sel: assert property ( // [RULE15]
		@(posedge clock_in) disable iff (srst_in)
		wr_en_in && addr_in == GCF_OFF_SEL2
		|=> sel_r[2] == $past(wdata_in))
		else $error("select write lost");

	a_write_mode_hi: assert property ( // [RULE8]
		@(posedge clock_in) disable iff (srst_in)
		wr_en_in && addr_in == GCF_OFF_MODE_HI
		|=> mode_hi_r == $past(wdata_in))
		else $error("upper pair write lost");

	a_reset_out: assert property ( // [RULE8]
		@(posedge clock_in)
		srst_in |=> pin_oe_out == 4'h0 && mode_hi_r == 8'h00)
		else $error("reset left pins driven");
endmodule

// [sim/gcf_board.sv]
// board model: pad level from device drive, external driver, pull-up
`timescale 1ns/1ps
module gcf_board (
	input  wire logic [3:0] drive_in,
	input  wire logic [3:0] oe_in,
	input  wire logic [3:0] ext_en_in,
	input  wire logic [3:0] ext_val_in,
	output logic      [3:0] pad_out
);
	// device drive wins, then external driver, else pull-up high
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pad_out[i] = ext_en_in[i] ? ext_val_in[i] : 1'b1;
			if (oe_in[i]) begin
				pad_out[i] = drive_in[i];
			end
		end
	end
endmodule

// [sim/tb_gpio_config_status_follow.sv]
// bench: pin modes, follow select, level register, register map
`timescale 1ns/1ps
module tb_gpio_config_status_follow;
	import gcf_pkg::*;
	logic         clock_in, srst_in, wr_en_in;
	logic [7:0]   addr_in, wdata_in, rdata_out, d;
	logic [255:0] st_bits, st_impl, st_deny;
	logic [3:0]   pad, pin_out, pin_oe_out, pin_value_out, ext_en, ext_val;
	logic [3:0]   m;
	logic [1:0]   e;
	logic         f;
	int           err_count, n_checks, p, r, b, k;
	logic [7:0]   offs [6] = '{GCF_OFF_MODE_LO, GCF_OFF_MODE_HI,
		GCF_OFF_SEL0, GCF_OFF_SEL1, GCF_OFF_SEL2, GCF_OFF_SEL3};
	gcf_top u_dut (.clock_in(clock_in), .srst_in(srst_in),
		.wr_en_in(wr_en_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.rdata_out(rdata_out), .status_bits_in(st_bits),
		.status_impl_in(st_impl), .status_deny_in(st_deny), .pin_in(pad),
		.pin_out(pin_out), .pin_oe_out(pin_oe_out),
		.pin_value_out(pin_value_out));
	gcf_board u_brd (.drive_in(pin_out), .oe_in(pin_oe_out),
		.ext_en_in(ext_en), .ext_val_in(ext_val), .pad_out(pad));
	// expected {oe, driven level} of one pin
	function automatic logic [1:0] exp_pin(input logic [3:0] mo, input logic fb);
		case (mo)
			4'h2: exp_pin = 2'h2;
			4'h3: exp_pin = 2'h3;
			4'h4: exp_pin = {1'b1, fb};
			4'h5: exp_pin = {1'b1, ~fb};
			4'h6: exp_pin = {~fb, 1'b0};
			4'h7: exp_pin = {fb, 1'b0};
			default: exp_pin = 2'h0;
		endcase
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock_in);
		addr_in <= a;
		wdata_in <= v;
		wr_en_in <= 1'b1;
		@(posedge clock_in);
		wr_en_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clock_in);
		addr_in <= a;
		repeat (2) @(posedge clock_in);
		#1 v = rdata_out;
	endtask
	task automatic results;
		if (err_count == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// clock generator
	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge clock_in);
		err_count++;
		results();
	end
	// main sequence
	initial begin
		{srst_in, wr_en_in, addr_in, wdata_in} = {1'b1, 17'h0};
		{st_bits, st_impl, st_deny, ext_en, ext_val} = '0;
		repeat (10) @(posedge clock_in);
		srst_in <= 1'b0;
		void'($urandom(46));
		// reset values, then write and read back every mode and select register
		foreach (offs[i]) begin
			rd(offs[i], d);
			check(d, 8'h00);
			m = 4'($urandom);
			wr(offs[i], {m, 4'h7 - m[2:0]});
			rd(offs[i], d);
			check(d, {m, 4'h7 - m[2:0]});
		end
		wr(8'h20, 8'hA5);
		rd(8'h20, d);
		check(d, 8'h00);
		// random pin modes with implemented, missing, denied follow targets
		for (int n = 0; n < 200; n++) begin
			p = $urandom % 4;
			// legal codes, every eighth one reserved on purpose
			m = (n % 8 == 7) ? 4'h8 | 4'($urandom) :
				4'($urandom % 8);
			k = $urandom % 4;
			r = (k == 3) ? 1 : $urandom % 32;
			b = $urandom % 8;
			@(posedge clock_in);
			st_bits <= {8{$urandom}};
			st_impl <= (k == 1) ? ~(256'h1 << (r * 8 + b)) : '1;
			st_deny <= (k == 2) ? (256'h1 << (r * 8 + b)) : '0;
			ext_en <= 4'($urandom);
			ext_val <= 4'($urandom);
			wr(p < 2 ? GCF_OFF_MODE_LO : GCF_OFF_MODE_HI, 8'(m) << 4 * (p % 2));
			wr(GCF_OFF_SEL0 + 8'(p), {5'(r), 3'(b)});
			repeat (4) @(posedge clock_in);
			#1;
			f = (k == 0 && r != 1) ? st_bits[r * 8 + b] : 1'b0;
			e = exp_pin(m, f);
			// unusable target in a status mode drives low
			if (m[3:2] == 2'h1 && (k != 0 || r == 1)) begin
				e = 2'h2;
			end
			check(pin_oe_out[p], e[1]);
			case (k)
				1: check(e[1] & pin_out[p], e[0]);
				2: check(e[1] & pin_out[p], e[0]);
				3: check(e[1] & pin_out[p], e[0]);
				default: check(e[1] & pin_out[p], e[0]);
			endcase
			if (m < 4'h2) begin
				check(pin_value_out[p], pad[p] ^ m[0]);
			end
			rd(GCF_OFF_LEVEL, d);
			check(d, {4'h0, pad});
			wr(GCF_OFF_MODE_LO, 8'h00);
			wr(GCF_OFF_MODE_HI, 8'h00);
		end
		results();
	end
endmodule
